// [core/tscp_defs.vh]
// constants for the three-wire serial control port
// assumes a single 25 MHz core clock and a host-driven shift clock
`ifndef TSCP_DEFS_VH
`define TSCP_DEFS_VH

// widths
`define TSCP_ADR_W 13
`define TSCP_BYTE_W 8
`define TSCP_CNT_W 3

// instruction word fields
`define TSCP_INS_RW 15
`define TSCP_INS_LEN_HI 14
`define TSCP_INS_LEN_LO 13
`define TSCP_INS_ADR_HI 12
`define TSCP_LEN_STREAM 2'h3

// bit counter values
`define TSCP_BIT_FIRST 3'h0
`define TSCP_BIT_LAST 3'h7
`define TSCP_BIT_ONE 3'h1

// in-port register offsets
`define TSCP_ADR_SPI_CTRL 13'h0000
`define TSCP_ADR_PORT_OPT 13'h0004
`define TSCP_ADR_UPDATE 13'h0005

// read-only windows, writes there are dropped
`define TSCP_ADR_ID_LO 13'h000A
`define TSCP_ADR_ID_HI 13'h000D
`define TSCP_ADR_STAT_LO 13'h0080
`define TSCP_ADR_STAT_HI 13'h0082

// field positions
`define TSCP_B_LSB_FIRST 6
`define TSCP_B_SOFT_RST 5
`define TSCP_B_HARD_RST 4
`define TSCP_B_REDUCE 1
`define TSCP_B_RD_BUF 0
`define TSCP_B_UPDATE 0

// reset values and fixed constants
`define TSCP_RST_BIT 1'h0
`define TSCP_RST_BYTE 8'h00
`define TSCP_RST_ADR 13'h0000
`define TSCP_RST_LEN 2'h0
`define TSCP_ADR_ONE 13'h0001
`define TSCP_FIFO_DEPTH 2
`define TSCP_FIFO_CW 2
`define TSCP_CNT_ONE 2'h1
`define TSCP_CNT_ZERO 2'h0

`endif

// [core/tscp_port.v]
// three-wire serial control port, slave side, with one shared data pin
// assumes: SCLK and CS come from the host asynchronously, sclk at most clk/8;
// register storage outside, reached by the write buffer and the read address/data ports
`default_nettype none
`include "tscp_defs.vh"

module tscp_port (
	input wire REF_CLK_IN,
	input wire NRST_IN,
	input wire SCLK_IN,
	input wire CS_N_IN,
	input wire SDIO_IN,
	output reg SDIO_OUT,
	output reg SDIO_OE_OUT,
	output reg [12:0] RD_ADDR_OUT,
	output reg RD_SHADOW_OUT,
	input wire [7:0] RD_DATA_IN,
	output reg WR_VALID_OUT,
	input wire WR_READY_IN,
	output wire [12:0] WR_ADDR_OUT,
	output wire [7:0] WR_DATA_OUT,
	output reg UPDATE_OUT,
	output reg LSB_FIRST_OUT,
	output reg REDUCE_DRIVE_OUT,
	output reg SOFT_RESET_OUT,
	output reg HARD_RESET_OUT,
	output reg OVERRUN_OUT
);

	localparam [1:0] ST_INSTR = 2'h0;
	localparam [1:0] ST_WRITE = 2'h1;
	localparam [1:0] ST_READ = 2'h2;

	// bit position for the k-th bit of a byte in the current order
	function [2:0] bit_pos;
		input lsb;
		input [2:0] k;
		begin
			bit_pos = lsb ? k : (`TSCP_BIT_LAST - k);
		end
	endfunction

	function is_ro;
		input [12:0] a;
		begin
			is_ro = ((a >= `TSCP_ADR_ID_LO) && (a <= `TSCP_ADR_ID_HI)) ||
				((a >= `TSCP_ADR_STAT_LO) && (a <= `TSCP_ADR_STAT_HI));
		end
	endfunction

	// synchronisers: stage _m only feeds stage _s
	reg sclk_m_r;
	reg sclk_s_r;
	reg sclk_d_r;
	reg cs_m_r;
	reg cs_s_r;
	reg sdio_m_r;
	reg sdio_s_r;

	reg [1:0] state_r;
	reg [2:0] bit_cnt_r;
	reg ins_hi_r;
	reg [7:0] ins_b0_r;
	reg [7:0] rx_r;
	reg [7:0] tx_r;
	reg [12:0] addr_r;
	reg [1:0] left_r;
	reg stream_r;
	reg rd_buf_r;
	reg upd_pend_r;

	reg [12:0] mem_a_r [0:1];
	reg [7:0] mem_d_r [0:1];
	reg [1:0] cnt_r;

	wire rise = sclk_s_r & ~sclk_d_r;
	wire fall = ~sclk_s_r & sclk_d_r;
	wire cs_hi = cs_s_r;
	wire byte_done = rise & ~cs_hi & (bit_cnt_r == `TSCP_BIT_LAST);
	// shift in per current order
	wire [7:0] rx_next = LSB_FIRST_OUT ? {sdio_s_r, rx_r[7:1]} : {rx_r[6:0], sdio_s_r};
	// first byte is the high half MSB-first, the low half LSB-first
	wire [15:0] ins_word = LSB_FIRST_OUT ? {rx_next, ins_b0_r} : {ins_b0_r, rx_next};
	wire [1:0] ins_len = ins_word[`TSCP_INS_LEN_HI:`TSCP_INS_LEN_LO];
	wire wr_byte = byte_done & (state_r == ST_WRITE);
	wire wr_local = (addr_r == `TSCP_ADR_SPI_CTRL) || (addr_r == `TSCP_ADR_PORT_OPT) ||
		(addr_r == `TSCP_ADR_UPDATE);
	wire push_req = wr_byte & ~wr_local & ~is_ro(addr_r);
	wire pop = WR_VALID_OUT & WR_READY_IN;
	wire push_ok = push_req & ((cnt_r != `TSCP_FIFO_DEPTH) | pop);
	wire [1:0] wr_idx = pop ? (cnt_r - `TSCP_CNT_ONE) : cnt_r;
	wire [1:0] cnt_nxt = cnt_r - {1'b0, pop} + {1'b0, push_ok};
	wire [7:0] local_rd = (addr_r == `TSCP_ADR_SPI_CTRL) ?
		({7'h00, LSB_FIRST_OUT} << `TSCP_B_LSB_FIRST) :
		(addr_r == `TSCP_ADR_PORT_OPT) ?
		(({7'h00, REDUCE_DRIVE_OUT} << `TSCP_B_REDUCE) |
		({7'h00, rd_buf_r} << `TSCP_B_RD_BUF)) : `TSCP_RST_BYTE;
	wire [7:0] rd_byte = wr_local ? local_rd : RD_DATA_IN;

	assign WR_ADDR_OUT = mem_a_r[0];
	assign WR_DATA_OUT = mem_d_r[0];

	always @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			sclk_m_r <= `TSCP_RST_BIT;
			sclk_s_r <= `TSCP_RST_BIT;
			sclk_d_r <= `TSCP_RST_BIT;
			cs_m_r <= 1'h1;
			cs_s_r <= 1'h1;
			sdio_m_r <= `TSCP_RST_BIT;
			sdio_s_r <= `TSCP_RST_BIT;
		end else begin
			sclk_m_r <= SCLK_IN;
			sclk_s_r <= sclk_m_r;
			sclk_d_r <= sclk_s_r;
			cs_m_r <= CS_N_IN;
			cs_s_r <= cs_m_r;
			sdio_m_r <= SDIO_IN;
			sdio_s_r <= sdio_m_r;
		end
	end

	// framing and address sequencing
	always @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state_r <= ST_INSTR;
			bit_cnt_r <= `TSCP_BIT_FIRST;
			ins_hi_r <= `TSCP_RST_BIT;
			ins_b0_r <= `TSCP_RST_BYTE;
			rx_r <= `TSCP_RST_BYTE;
			addr_r <= `TSCP_RST_ADR;
			left_r <= `TSCP_RST_LEN;
			stream_r <= `TSCP_RST_BIT;
		end else if (cs_hi) begin
			if (bit_cnt_r != `TSCP_BIT_FIRST) begin
				// partial byte: drop everything, back to idle
				state_r <= ST_INSTR;
				bit_cnt_r <= `TSCP_BIT_FIRST;
				ins_hi_r <= `TSCP_RST_BIT;
			end else if (stream_r && state_r != ST_INSTR) begin
				// streaming ends at the first boundary with select high
				state_r <= ST_INSTR;
			end
			// otherwise a fixed-length stall: hold everything
		end else if (rise) begin
			bit_cnt_r <= bit_cnt_r + `TSCP_BIT_ONE;
			rx_r <= rx_next;
			if (bit_cnt_r == `TSCP_BIT_LAST) begin
				case (state_r)
					ST_INSTR: begin
						if (!ins_hi_r) begin
							ins_b0_r <= rx_next;
							ins_hi_r <= 1'h1;
						end else begin
							// sixteenth edge: decode the word
							ins_hi_r <= `TSCP_RST_BIT;
							addr_r <= ins_word[`TSCP_INS_ADR_HI:0];
							left_r <= ins_len;
							stream_r <= (ins_len == `TSCP_LEN_STREAM);
							state_r <= ins_word[`TSCP_INS_RW] ? ST_READ : ST_WRITE;
						end
					end
					ST_WRITE, ST_READ: begin
						// plain +/-1 with wrap, no address skipped
						addr_r <= LSB_FIRST_OUT ? (addr_r + `TSCP_ADR_ONE) :
							(addr_r - `TSCP_ADR_ONE);
						if (!stream_r) begin
							if (left_r == `TSCP_RST_LEN)
								state_r <= ST_INSTR;
							else
								left_r <= left_r - `TSCP_CNT_ONE;
						end
					end
					default: begin
						state_r <= ST_INSTR;
					end
				endcase
			end
		end
	end

	// read data onto the pin on falling edges
	always @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			SDIO_OUT <= `TSCP_RST_BIT;
			SDIO_OE_OUT <= `TSCP_RST_BIT;
			tx_r <= `TSCP_RST_BYTE;
			RD_ADDR_OUT <= `TSCP_RST_ADR;
			RD_SHADOW_OUT <= `TSCP_RST_BIT;
		end else begin
			RD_ADDR_OUT <= addr_r;
			RD_SHADOW_OUT <= rd_buf_r;
			if (cs_hi || state_r != ST_READ) begin
				SDIO_OE_OUT <= `TSCP_RST_BIT;
			end else if (fall) begin
				// drive starts and data changes only on falling edges; release comes off any edge
				SDIO_OE_OUT <= 1'h1;
				if (bit_cnt_r == `TSCP_BIT_FIRST) begin
					tx_r <= rd_byte;
					SDIO_OUT <= rd_byte[bit_pos(LSB_FIRST_OUT, bit_cnt_r)];
				end else begin
					SDIO_OUT <= tx_r[bit_pos(LSB_FIRST_OUT, bit_cnt_r)];
				end
			end
		end
	end

	// in-port registers; order change takes effect on the next byte
	always @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			LSB_FIRST_OUT <= `TSCP_RST_BIT;
			REDUCE_DRIVE_OUT <= `TSCP_RST_BIT;
			rd_buf_r <= `TSCP_RST_BIT;
			SOFT_RESET_OUT <= `TSCP_RST_BIT;
			HARD_RESET_OUT <= `TSCP_RST_BIT;
			upd_pend_r <= `TSCP_RST_BIT;
			UPDATE_OUT <= `TSCP_RST_BIT;
			OVERRUN_OUT <= `TSCP_RST_BIT;
		end else begin
			SOFT_RESET_OUT <= wr_byte & (addr_r == `TSCP_ADR_SPI_CTRL) &
				rx_next[`TSCP_B_SOFT_RST];
			HARD_RESET_OUT <= wr_byte & (addr_r == `TSCP_ADR_PORT_OPT) &
				rx_next[`TSCP_B_HARD_RST];
			if (wr_byte && addr_r == `TSCP_ADR_SPI_CTRL)
				LSB_FIRST_OUT <= rx_next[`TSCP_B_LSB_FIRST];
			if (wr_byte && addr_r == `TSCP_ADR_PORT_OPT) begin
				rd_buf_r <= rx_next[`TSCP_B_RD_BUF];
				REDUCE_DRIVE_OUT <= rx_next[`TSCP_B_REDUCE];
			end
			// update waits for queued shadow writes so none lands after it
			// pending flag clears one edge late, so mask it to keep a single-cycle pulse
			UPDATE_OUT <= upd_pend_r & ~UPDATE_OUT & (cnt_r == `TSCP_CNT_ZERO) & ~push_req;
			if (wr_byte && addr_r == `TSCP_ADR_UPDATE && rx_next[`TSCP_B_UPDATE])
				upd_pend_r <= 1'h1;
			else if (UPDATE_OUT)
				upd_pend_r <= `TSCP_RST_BIT;
			// the host cannot be stalled, so a full buffer can only be reported
			if (push_req && !push_ok)
				OVERRUN_OUT <= 1'h1;
			else if (rise && !cs_hi && state_r == ST_INSTR && !ins_hi_r &&
				bit_cnt_r == `TSCP_BIT_FIRST)
				OVERRUN_OUT <= `TSCP_RST_BIT;
		end
	end

	// two-entry shadow write buffer, head is entry 0
	integer i;
	always @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cnt_r <= `TSCP_CNT_ZERO;
			WR_VALID_OUT <= `TSCP_RST_BIT;
			for (i = 0; i < `TSCP_FIFO_DEPTH; i = i + 1) begin
				mem_a_r[i] <= `TSCP_RST_ADR;
				mem_d_r[i] <= `TSCP_RST_BYTE;
			end
		end else begin
			cnt_r <= cnt_nxt;
			WR_VALID_OUT <= (cnt_nxt != `TSCP_CNT_ZERO);
			for (i = 0; i < `TSCP_FIFO_DEPTH; i = i + 1) begin
				if (push_ok && wr_idx == i[1:0]) begin
					mem_a_r[i] <= addr_r;
					mem_d_r[i] <= rx_next;
				end else if (pop && i == 0) begin
					mem_a_r[0] <= mem_a_r[1];
					mem_d_r[0] <= mem_d_r[1];
				end
			end
		end
	end

endmodule // tscp_port
`default_nettype wire

// [bench/tscp_port_chk.sv]
// assertions on the serial control port pins and write port
// bound to tscp_port, sees only its ports
`default_nettype none
module tscp_port_chk (
	input wire logic REF_CLK_IN,
	input wire logic NRST_IN,
	input wire logic SCLK_IN,
	input wire logic CS_N_IN,
	input wire logic SDIO_OUT,
	input wire logic SDIO_OE_OUT,
	input wire logic WR_VALID_OUT,
	input wire logic WR_READY_IN,
	input wire logic [12:0] WR_ADDR_OUT,
	input wire logic [7:0] WR_DATA_OUT,
	input wire logic UPDATE_OUT,
	input wire logic LSB_FIRST_OUT,
	input wire logic OVERRUN_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!NRST_IN);
	a_pin_released: assert property (CS_N_IN [*5] |-> !SDIO_OE_OUT)
		else $error("pin driven while deselected");
	a_oe_selected: assert property (SDIO_OE_OUT |-> !$past(CS_N_IN, 5))
		else $error("pin driven without select");
	a_bit_steady: assert property (SDIO_OE_OUT && SCLK_IN && $past(SCLK_IN) |-> $stable(SDIO_OUT))
		else $error("read bit moved while clock high");
	a_oe_on_low: assert property ($rose(SDIO_OE_OUT) |-> !SCLK_IN && !CS_N_IN)
		else $error("drive began off a falling edge");
	a_update_once: assert property (UPDATE_OUT |-> !WR_VALID_OUT ##1 !UPDATE_OUT)
		else $error("update pulse wrong");
	a_lsb_in_cycle: assert property ($changed(LSB_FIRST_OUT) |-> !$past(CS_N_IN, 5))
		else $error("bit order moved outside a cycle");
	a_ovr_full: assert property ($rose(OVERRUN_OUT) |-> WR_VALID_OUT && !$past(WR_READY_IN))
		else $error("overrun with room left");
	a_head_hold: assert property (WR_VALID_OUT && !WR_READY_IN |=> WR_VALID_OUT
		&& $stable({WR_ADDR_OUT, WR_DATA_OUT}))
		else $error("write head lost");
	c_update: cover property (UPDATE_OUT);
	c_lsb_read: cover property (LSB_FIRST_OUT && SDIO_OE_OUT);
	c_overrun: cover property ($rose(OVERRUN_OUT));
endmodule // tscp_port_chk
bind tscp_port tscp_port_chk i_chk (.*);
`default_nettype wire

// [bench/tscp_host.sv]
// serial master model: drives clock, select and the shared data wire
// bench calls its tasks; data wire resolved here from both enables
`default_nettype none
module tscp_host (
	input wire logic clk,
	input wire logic dev_out,
	input wire logic dev_oe,
	output logic sclk,
	output logic cs_n,
	output wire logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic lsb = 1'b0;
	logic drv = 1'b0;
	logic mosi = 1'b0;
	logic last_v = 1'b0;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
	end
	// released wire toggles so a stale bit cannot pass
	assign line = dev_oe ? dev_out : (drv ? mosi : ~last_v);
	always @(posedge clk) last_v <= line;
	task automatic clks(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic xbyte(input logic [7:0] b, input int nb, input logic rd,
		output logic [7:0] got);
		int k;
		got = 8'h00;
		for (int i = 0; i < nb; i++) begin
			k = lsb ? i : 7 - i;
			sclk = 1'b0;
			drv = !rd;
			mosi = b[k];
			clks(4);
			got[k] = line;
			sclk = 1'b1;
			clks(4);
		end
	endtask
	task automatic open_f();
		cs_n = 1'b0;
	endtask
	task automatic stall_f();
		cs_n = 1'b1;
		clks(8);
		cs_n = 1'b0;
	endtask
	task automatic close_f();
		cs_n = 1'b1;
		drv = 1'b0;
		clks(12);
	endtask
	task automatic cmd(input logic rd, input logic [1:0] len, input logic [12:0] a);
		logic [15:0] w;
		logic [7:0] g;
		w = {rd, len, a};
		xbyte(lsb ? w[7:0] : w[15:8], 8, 1'b0, g);
		xbyte(lsb ? w[15:8] : w[7:0], 8, 1'b0, g);
	endtask
endmodule // tscp_host
`default_nettype wire

// [bench/tscp_port_tb.sv]
// self-checking bench for the serial control port
// host model drives the pins; register store is modelled here
`default_nettype none
module tscp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic nrst_n = 1'b0;
	logic wr_ready = 1'b0;
	logic hold = 1'b1;
	logic shadow_x = 1'b0;
	logic sclk, cs_n, line, sdio_out, sdio_oe, rd_shadow, wr_valid, update, lsb_first, overrun;
	logic reduce, soft_rst, hard_rst;
	int n_soft = 0;
	int n_hard = 0;
	logic [12:0] rd_addr, wr_addr;
	logic [7:0] rd_data, wr_data;
	logic [20:0] exq[$];
	logic [20:0] gotq[$];
	int n_errors = 0;
	int n_checks = 0;
	int n_upd = 0;
	initial forever #20 clk = ~clk;
	function automatic logic [7:0] reg_val(input logic [12:0] a, input logic s);
		return a[7:0] ^ a[12:5] ^ {7'h00, s};
	endfunction
	assign rd_data = reg_val(rd_addr, rd_shadow);
	always @(negedge clk) wr_ready <= hold ? 1'b0 : 1'($urandom);
	always @(posedge clk) begin
		if (wr_valid === 1'b1 && wr_ready === 1'b1)
			gotq.push_back({wr_addr, wr_data});
		if (update === 1'b1)
			n_upd++;
		if (soft_rst === 1'b1)
			n_soft++;
		if (hard_rst === 1'b1)
			n_hard++;
	end
	tscp_port i_dut (.REF_CLK_IN(clk), .NRST_IN(nrst_n), .SCLK_IN(sclk), .CS_N_IN(cs_n),
		.SDIO_IN(line), .SDIO_OUT(sdio_out), .SDIO_OE_OUT(sdio_oe), .RD_ADDR_OUT(rd_addr),
		.RD_SHADOW_OUT(rd_shadow), .RD_DATA_IN(rd_data), .WR_VALID_OUT(wr_valid),
		.WR_READY_IN(wr_ready), .WR_ADDR_OUT(wr_addr), .WR_DATA_OUT(wr_data),
		.UPDATE_OUT(update), .LSB_FIRST_OUT(lsb_first), .REDUCE_DRIVE_OUT(reduce),
		.SOFT_RESET_OUT(soft_rst), .HARD_RESET_OUT(hard_rst), .OVERRUN_OUT(overrun));
	tscp_host i_host (.clk(clk), .dev_out(sdio_out), .dev_oe(sdio_oe), .sclk(sclk),
		.cs_n(cs_n), .line(line));
	task automatic final_report();
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [20:0] seen, input logic [20:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic drain();
		for (int i = 0; i < 300 && gotq.size() < exq.size(); i++)
			@(negedge clk);
		if (gotq.size() != exq.size()) begin
			n_errors++;
			$display("BAD %0t write count", $time);
			final_report();
		end
		while (exq.size() > 0)
			check(gotq.pop_front(), exq.pop_front());
	endtask
	task automatic wr(input logic [12:0] a, input logic [1:0] len, input int n,
		input logic [23:0] d, input logic sh);
		logic [7:0] g;
		i_host.open_f();
		i_host.cmd(1'b0, len, a);
		for (int i = 0; i < n; i++) begin
			i_host.xbyte(d[8*i+:8], 8, 1'b0, g);
			if (sh)
				exq.push_back({a, d[8*i+:8]});
			a = i_host.lsb ? a + 13'h0001 : a - 13'h0001;
			if (len != 2'h3 && i < n - 1 && $urandom % 2)
				i_host.stall_f();
		end
		i_host.close_f();
	endtask
	task automatic rd(input logic [12:0] a, input logic [1:0] len, input int n);
		logic [7:0] g;
		i_host.open_f();
		i_host.cmd(1'b1, len, a);
		for (int i = 0; i < n; i++) begin
			i_host.xbyte(8'h00, 8, 1'b1, g);
			check({13'h0000, g}, {13'h0000, reg_val(a, shadow_x)});
			a = i_host.lsb ? a + 13'h0001 : a - 13'h0001;
		end
		i_host.close_f();
	endtask
	initial begin
		logic [12:0] a;
		logic [1:0] len;
		logic [7:0] g;
		void'($urandom(25));
		repeat (12) @(negedge clk);
		nrst_n = 1'b1;
		repeat (4) @(negedge clk);
		hold = 1'b0;
		for (int t = 0; t < 6; t++) begin
			// spans stay clear of reserved and unused locations
			a = 13'h0100 + 13'($urandom % 7680);
			len = 2'($urandom % 3);
			wr(a, len, int'(len) + 1, 24'($urandom), 1'b1);
			drain();
			rd(a, t == 5 ? 2'h3 : len, t == 5 ? 4 : int'(len) + 1);
		end
		// partial byte then deselect must leave nothing behind
		i_host.open_f();
		i_host.xbyte(8'hFF, 5, 1'b0, g);
		i_host.close_f();
		wr(13'h0123, 2'h0, 1, 24'h00005A, 1'b1);
		drain();
		wr(13'h0005, 2'h0, 1, 24'h000001, 1'b0);
		repeat (4) @(negedge clk);
		check(21'(n_upd), 21'h000001);
		wr(13'h0000, 2'h0, 1, 24'h000020, 1'b0);
		wr(13'h0004, 2'h0, 1, 24'h000013, 1'b0);
		repeat (4) @(negedge clk);
		check(21'(n_soft), 21'h000001);
		check(21'(n_hard), 21'h000001);
		check({20'h00000, reduce}, 21'h000001);
		check({20'h00000, lsb_first}, 21'h000000);
		shadow_x = 1'b1;
		rd(13'h0300, 2'h1, 2);
		hold = 1'b1;
		wr(13'h0200, 2'h3, 3, 24'h332211, 1'b1);
		void'(exq.pop_back());
		check({20'h00000, overrun}, 21'h000001);
		hold = 1'b0;
		drain();
		wr(13'h0000, 2'h0, 1, 24'h000040, 1'b0);
		i_host.lsb = 1'b1;
		check({20'h00000, lsb_first}, 21'h000001);
		wr(13'h0400, 2'h2, 3, 24'($urandom), 1'b1);
		drain();
		rd(13'h0400, 2'h2, 3);
		final_report();
	end
endmodule // tscp_port_tb
`default_nettype wire
